// ---- rtl/eid_pkg.sv ----
// Purpose: shared constants of the interrupt detect and acknowledge front end
// Assumes: one system clock, synchronous active-high reset
// Notes:   source indices fix the layout of every flag vector
`default_nettype none
package eid_pkg;
    localparam int unsigned N_EXT      = 4;
    localparam int unsigned N_SRC      = 9;
    localparam int unsigned SRC_W      = 4;
    localparam int unsigned HIST_W     = 4;
    // source positions in the flag vectors
    localparam int unsigned SRC_NMI    = 0;
    localparam int unsigned SRC_EXT0   = 1;
    localparam int unsigned SRC_TIMER0 = 5;
    localparam int unsigned SRC_TIMER1 = 6;
    localparam int unsigned SRC_WDOG   = 7;
    localparam int unsigned SRC_HOST   = 8;
    // pin-as-interrupt configuration bits
    localparam int unsigned CFG_TIMER0 = 0;
    localparam int unsigned CFG_TIMER1 = 1;
    localparam int unsigned CFG_WDOG   = 2;
    localparam int unsigned CFG_HOST   = 3;
    localparam int unsigned N_CFG      = 4;
    // sample patterns, oldest sample in the top bit
    localparam logic [HIST_W-1:0] PAT_LOW_PULSE = 4'h8;  // 1-0-0-0
    localparam logic [HIST_W-1:0] PAT_SPACED    = 4'hE;  // 1-1-1-0 after a low
    localparam logic [HIST_W-1:0] HIST_RST      = 4'h0;
    localparam logic [N_SRC-1:0]  FLAGS_RST     = 9'h000;
    localparam logic              ACK_IDLE      = 1'b1;
endpackage : eid_pkg
`default_nettype wire

// ---- rtl/eid_det_if.sv ----
// Purpose: carries one pin and its detect strobe between top and detector
// Assumes: pin is asynchronous to clk_sys_i
// Notes:   hit is high for one full clock period per detection
`default_nettype none
interface eid_det_if;
    logic pin;
    logic hit;
    modport det (input pin, output hit);
    modport ctl (output pin, input hit);
endinterface : eid_det_if
`default_nettype wire

// ---- rtl/eid_pin_detect.sv ----
// Purpose: synchronise one interrupt pin and match a sample pattern
// Assumes: PATTERN lists consecutive samples, oldest first
// Notes:   history is sampled on the falling clock edge
`default_nettype none
module eid_pin_detect
    import eid_pkg::*;
#(
    parameter logic [HIST_W-1:0] PATTERN = PAT_LOW_PULSE
) (
    input  wire logic clk_sys_i,  // system clock
    input  wire logic rst_i,      // sync reset, high
    eid_det_if.det    port        // pin in, hit out
);
    logic              sync1;
    logic              sync2;
    logic [HIST_W-1:0] hist;
    logic [HIST_W-1:0] next_hist;
    logic              hit;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= port.pin;
            sync2 <= sync1;
        end
    end

    assign next_hist = {hist[HIST_W-2:0], sync2};

    always_ff @(negedge clk_sys_i) begin
        if (rst_i) begin
            hist <= HIST_RST;
            hit  <= 1'b0;
        end else begin
            hist <= next_hist;
            hit  <= (next_hist == PATTERN);
        end
    end

    assign port.hit = hit;

    property p_sync_depth;
        @(posedge clk_sys_i) disable iff (rst_i)
        !$past(rst_i, 2) |-> sync2 == $past(port.pin, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("pin not two stages deep");

    property p_fall_sample;
        @(negedge clk_sys_i) disable iff (rst_i)
        !$past(rst_i) |-> hist[0] == $past(sync2);
    endproperty
    a_fall_sample: assert property (p_fall_sample) else $error("sample not on falling edge");

    property p_hit_pattern;
        @(posedge clk_sys_i) disable iff (rst_i)
        hit |-> hist == PATTERN;
    endproperty
    a_hit_pattern: assert property (p_hit_pattern) else $error("hit without its sample pattern");

    property p_no_double;
        @(posedge clk_sys_i) disable iff (rst_i)
        hit |=> !hit;
    endproperty
    a_no_double: assert property (p_no_double) else $error("hit longer than one cycle");
endmodule : eid_pin_detect
`default_nettype wire

// ---- rtl/eid_top.sv ----
// Purpose: interrupt pin detection, pending flags and acknowledge strobe
// Assumes: cpu side signals are synchronous to clk_sys_i
// Notes:   source 0 is nonmaskable; others need their enable bit
//
// Notes on behaviour
// - two flip-flop synchroniser on every interrupt pin
// - sample synchronised pins on falling clock edge
// - detect on 1-0-0-0; source holds three lows
// - configured timer/watchdog/host pins raise own interrupt
// - consecutive strobe interrupts need 0-1-1-1-0
// - vector fetch asserts acknowledge, clears pending flag
// - acknowledge low exactly one clock, then high
// - masked interrupt: no acknowledge, no branch
// - hard reset clears all; soft clears flags
`default_nettype none
module eid_top
    import eid_pkg::*;
(
    input  wire logic             clk_sys_i,            // 200 MHz system clock
    input  wire logic             rst_i,                // hardware reset, sync, high
    input  wire logic             nmi_n_i,              // nonmaskable interrupt pin
    input  wire logic [N_EXT-1:0] ext_int_n_i,          // external interrupt pins
    input  wire logic             timer0_pin_i,         // timer 0 pin
    input  wire logic             timer1_pin_i,         // timer 1 pin
    input  wire logic             watchdog_out_pin_i,   // watchdog output pin
    input  wire logic             host_address_strobe_i,// host address strobe pin
    input  wire logic [N_CFG-1:0] pin_as_irq_i,         // pin used as interrupt
    input  wire logic             soft_reset_i,         // software reset pulse
    input  wire logic             enable_wr_i,          // write enable bits
    input  wire logic [N_SRC-1:0] enable_wdata_i,       // enable write data
    input  wire logic             dbg_enable_wr_i,      // write debug enable bits
    input  wire logic [N_SRC-1:0] dbg_enable_wdata_i,   // debug enable write data
    input  wire logic             cpu_halted_i,         // cpu halted in debug
    input  wire logic             vector_fetch_i,       // first vector word fetch
    input  wire logic [SRC_W-1:0] vector_src_i,         // source being fetched
    output logic [N_SRC-1:0]      pending_flag_regs_o,  // pending flags
    output logic [N_SRC-1:0]      irq_enable_regs_o,    // enable bits
    output logic [N_SRC-1:0]      debug_irq_enable_regs_o, // debug enable bits
    output logic [N_SRC-1:0]      irq_request_o,        // serviceable requests
    output logic                  interrupt_acknowledge_n_o // acknowledge, low
);
    logic [N_SRC-1:0] raw_pin;
    logic [N_SRC-1:0] hit;
    logic [N_SRC-1:0] gate;
    logic [N_SRC-1:0] set_vec;
    logic [N_SRC-1:0] clr_vec;
    logic [N_SRC-1:0] pending;
    logic [N_SRC-1:0] enable;
    logic [N_SRC-1:0] dbg_enable;
    logic [N_SRC-1:0] serviceable;
    logic [N_SRC-1:0] next_pending;
    logic             src_valid;
    logic             fetch_ok;
    logic             ack_n;

    assign raw_pin[SRC_NMI]                  = nmi_n_i;
    assign raw_pin[SRC_EXT0 +: N_EXT]        = ext_int_n_i;
    assign raw_pin[SRC_TIMER0]               = timer0_pin_i;
    assign raw_pin[SRC_TIMER1]               = timer1_pin_i;
    assign raw_pin[SRC_WDOG]                 = watchdog_out_pin_i;
    assign raw_pin[SRC_HOST]                 = host_address_strobe_i;

    // one detector per source; the host strobe needs its spacing pattern
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_det
            eid_det_if det_if ();
            assign det_if.pin = raw_pin[g];
            assign hit[g]     = det_if.hit;
            eid_pin_detect #(
                .PATTERN ((g == SRC_HOST) ? PAT_SPACED : PAT_LOW_PULSE)
            ) u_det (
                .clk_sys_i (clk_sys_i),
                .rst_i     (rst_i),
                .port      (det_if.det)
            );
        end
    endgenerate

    // module pins only count while configured as interrupt inputs
    always_comb begin
        gate             = '1;
        gate[SRC_TIMER0] = pin_as_irq_i[CFG_TIMER0];
        gate[SRC_TIMER1] = pin_as_irq_i[CFG_TIMER1];
        gate[SRC_WDOG]   = pin_as_irq_i[CFG_WDOG];
        gate[SRC_HOST]   = pin_as_irq_i[CFG_HOST];
    end

    assign set_vec = hit & gate;

    // nmi is always serviceable; halted cpu also needs the debug enable
    always_comb begin
        serviceable          = enable & (cpu_halted_i ? dbg_enable : '1);
        serviceable[SRC_NMI] = 1'b1;
    end

    assign irq_request_o = pending & serviceable;
    assign src_valid     = vector_src_i < SRC_W'(N_SRC);

    // ack stays one clock: a fetch during a low acknowledge is ignored
    assign fetch_ok = vector_fetch_i && ack_n && src_valid
                      && irq_request_o[vector_src_i[SRC_W-1:0]];

    always_comb begin
        clr_vec = '0;
        if (soft_reset_i) begin
            clr_vec = '1;
        end else if (fetch_ok) begin
            clr_vec[vector_src_i] = 1'b1;
        end
    end

    // a detection in the clearing cycle survives
    assign next_pending = (pending & ~clr_vec) | set_vec;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pending <= FLAGS_RST;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            enable <= FLAGS_RST;
        end else if (enable_wr_i) begin
            enable <= enable_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dbg_enable <= FLAGS_RST;
        end else if (dbg_enable_wr_i) begin
            dbg_enable <= dbg_enable_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_n <= ACK_IDLE;
        end else begin
            ack_n <= !fetch_ok;
        end
    end

    assign pending_flag_regs_o       = pending;
    assign irq_enable_regs_o         = enable;
    assign debug_irq_enable_regs_o   = dbg_enable;
    assign interrupt_acknowledge_n_o = ack_n;

    sequence s_ack_pulse;
        !interrupt_acknowledge_n_o ##1 interrupt_acknowledge_n_o;
    endsequence

    property p_ack_one_clock;
        @(posedge clk_sys_i) disable iff (rst_i)
        fetch_ok |=> s_ack_pulse;
    endproperty
    a_ack_one_clock: assert property (p_ack_one_clock) else $error("acknowledge not one clock low");

    property p_ack_clears;
        @(posedge clk_sys_i) disable iff (rst_i)
        fetch_ok && !set_vec[vector_src_i] |=> !pending[$past(vector_src_i)];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("acknowledge left flag set");

    property p_ack_has_cause;
        @(posedge clk_sys_i) disable iff (rst_i)
        $fell(interrupt_acknowledge_n_o) |-> $past(vector_fetch_i) && $past(irq_request_o != '0);
    endproperty
    a_ack_has_cause: assert property (p_ack_has_cause) else $error("acknowledge without fetch");

    property p_masked_no_ack;
        @(posedge clk_sys_i) disable iff (rst_i)
        vector_fetch_i && src_valid && vector_src_i != SRC_W'(SRC_NMI) && !enable[vector_src_i]
        |=> interrupt_acknowledge_n_o;
    endproperty
    a_masked_no_ack: assert property (p_masked_no_ack) else $error("masked interrupt acknowledged");

    property p_pin_raises_own;
        @(posedge clk_sys_i) disable iff (rst_i)
        hit[SRC_HOST] && pin_as_irq_i[CFG_HOST] |=> pending[SRC_HOST];
    endproperty
    a_pin_raises_own: assert property (p_pin_raises_own) else $error("strobe did not raise host interrupt");

    property p_unconfigured_quiet;
        @(posedge clk_sys_i) disable iff (rst_i)
        !pending[SRC_TIMER0] && !pin_as_irq_i[CFG_TIMER0] |=> !pending[SRC_TIMER0];
    endproperty
    a_unconfigured_quiet: assert property (p_unconfigured_quiet) else $error("timer pin raised while unused");

    property p_hard_reset;
        @(posedge clk_sys_i)
        rst_i |=> pending == '0 && enable == '0 && dbg_enable == '0;
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("hard reset left bits set");

    property p_soft_reset;
        @(posedge clk_sys_i) disable iff (rst_i)
        soft_reset_i && set_vec == '0 && !enable_wr_i |=> pending == '0 && $stable(enable);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_ack_returns_high;
        @(posedge clk_sys_i) disable iff (rst_i)
        !interrupt_acknowledge_n_o |=> interrupt_acknowledge_n_o;
    endproperty
    a_ack_returns_high: assert property (p_ack_returns_high) else $error("acknowledge low two clocks");

    property p_flag_stands;
        @(posedge clk_sys_i) disable iff (rst_i)
        !soft_reset_i && !fetch_ok |=> (pending & $past(pending)) == $past(pending);
    endproperty
    a_flag_stands: assert property (p_flag_stands) else $error("pending flag lost without clear");

    property p_set_wins;
        @(posedge clk_sys_i) disable iff (rst_i)
        set_vec != '0 |=> (pending & $past(set_vec)) == $past(set_vec);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("detection lost in clearing cycle");
endmodule : eid_top
`default_nettype wire

// ---- test/eid_src_model.sv ----
// Purpose: interrupt sources beyond the pins: nmi, external, timer, watchdog, host strobe
// Assumes: all pins idle high, changed on the falling clock edge
// Notes:   bit index of pins_n_o equals the source index of the design
`default_nettype none
module eid_src_model
    import eid_pkg::*;
(
    input  wire logic             clk_sys_i,  // system clock
    output logic      [N_SRC-1:0] pins_n_o    // source pins, low active
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins_n_o = '1;

    // lows cycles low; if gap > 0, gap highs then a one-cycle second low
    task automatic pulse(input int src, input int lows, input int gap);
        @(negedge clk_sys_i);
        pins_n_o[src] = 1'b0;
        repeat (lows) @(negedge clk_sys_i);
        pins_n_o[src] = 1'b1;
        if (gap > 0) begin
            repeat (gap) @(negedge clk_sys_i);
            pins_n_o[src] = 1'b0;
            @(negedge clk_sys_i);
            pins_n_o[src] = 1'b1;
        end
    endtask : pulse
endmodule : eid_src_model
`default_nettype wire

// ---- test/ext_irq_detect_ack_tb_top.sv ----
// Purpose: self-checking bench of the interrupt detect and acknowledge front end
// Assumes: inputs change on the falling edge, outputs read there
// Notes:   cpu halted mode is not exercised
`default_nettype none
module ext_irq_detect_ack_tb_top
    import eid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk_sys_i = 1'b0;
    logic             rst_i     = 1'b1;
    logic [N_SRC-1:0] pins_n;
    logic [N_CFG-1:0] pin_as_irq = 4'hF;
    logic             soft_reset = 1'b0;
    logic             enable_wr = 1'b0;
    logic [N_SRC-1:0] enable_wdata = 9'h000;
    logic             dbg_wr = 1'b0;
    logic [N_SRC-1:0] dbg_wdata = 9'h000;
    logic             fetch = 1'b0;
    logic [SRC_W-1:0] fetch_src = 4'h0;
    logic [N_SRC-1:0] pending, enables, dbg_enables, request;
    logic             ack_n;
    int               err_total = 0;
    int               check_count = 0;
    int               cyc = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    eid_src_model i_eid_src_model (.clk_sys_i(clk_sys_i), .pins_n_o(pins_n));

    eid_top i_eid_top (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .nmi_n_i(pins_n[SRC_NMI]),
        .ext_int_n_i(pins_n[SRC_EXT0+:N_EXT]), .timer0_pin_i(pins_n[SRC_TIMER0]),
        .timer1_pin_i(pins_n[SRC_TIMER1]), .watchdog_out_pin_i(pins_n[SRC_WDOG]),
        .host_address_strobe_i(pins_n[SRC_HOST]), .pin_as_irq_i(pin_as_irq),
        .soft_reset_i(soft_reset), .enable_wr_i(enable_wr), .enable_wdata_i(enable_wdata),
        .dbg_enable_wr_i(dbg_wr), .dbg_enable_wdata_i(dbg_wdata), .cpu_halted_i(1'b0),
        .vector_fetch_i(fetch), .vector_src_i(fetch_src), .pending_flag_regs_o(pending),
        .irq_enable_regs_o(enables), .debug_irq_enable_regs_o(dbg_enables),
        .irq_request_o(request), .interrupt_acknowledge_n_o(ack_n));

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input logic [N_SRC-1:0] seen, input logic [N_SRC-1:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // bounded wait for a pending flag, reading on the falling edge
    task automatic wait_flag(input int src);
        for (int i = 0; i < 12 && pending[src] !== 1'b1; i++) @(negedge clk_sys_i);
    endtask : wait_flag

    task automatic fetch_vec(input int src);
        @(negedge clk_sys_i);
        fetch = 1'b1;
        fetch_src = src[SRC_W-1:0];
        @(negedge clk_sys_i);
        fetch = 1'b0;
    endtask : fetch_vec

    task automatic soft_pulse();
        @(negedge clk_sys_i);
        soft_reset = 1'b1;
        @(negedge clk_sys_i);
        soft_reset = 1'b0;
    endtask : soft_pulse

    task automatic test_reset_and_writes();
        check(pending, FLAGS_RST, "flags after reset");
        check(enables, 9'h000, "enables after reset");
        check(dbg_enables, 9'h000, "debug enables after reset");
        check({8'h00, ack_n}, {8'h00, ACK_IDLE}, "ack idle");
        dbg_wr = 1'b1;
        dbg_wdata = 9'h0A5;
        enable_wr = 1'b1;
        enable_wdata = 9'h1FD;
        @(negedge clk_sys_i);
        dbg_wr = 1'b0;
        enable_wr = 1'b0;
        check(dbg_enables, 9'h0A5, "debug enables written");
        check(enables, 9'h1FD, "enables written");
    endtask : test_reset_and_writes

    task automatic test_all_sources();
        for (int s = 0; s < N_SRC; s++) begin
            i_eid_src_model.pulse(s, 3, 0);
            wait_flag(s);
            check({8'h00, pending[s]}, 9'h001, "source detected");
        end
        check(pending, 9'h1FF, "all flags pending");
    endtask : test_all_sources

    task automatic test_ack_mask_soft();
        check(request, 9'h1FD, "masked source not requested");
        fetch_vec(SRC_EXT0);
        check({8'h00, ack_n}, 9'h001, "masked source no ack");
        check(pending, 9'h1FF, "masked flag kept");
        fetch_vec(3);
        check({8'h00, ack_n}, 9'h000, "ack low after fetch");
        check(pending, 9'h1F7, "acked flag cleared");
        @(negedge clk_sys_i);
        check({8'h00, ack_n}, 9'h001, "ack high after one cycle");
        soft_pulse();
        check(pending, 9'h000, "soft reset clears flags");
        check(enables, 9'h1FD, "soft reset keeps enables");
        // hard reset in mid-run must clear enables and debug enables too
        @(negedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        check(pending, FLAGS_RST, "flags after mid-run reset");
        check(enables, 9'h000, "enables after mid-run reset");
        check(dbg_enables, 9'h000, "debug enables after mid-run reset");
        check({8'h00, ack_n}, {8'h00, ACK_IDLE}, "ack idle after mid-run reset");
    endtask : test_ack_mask_soft

    task automatic test_refusals();
        i_eid_src_model.pulse(2, 2, 0);
        wait_flag(2);
        check(pending, 9'h000, "two-sample low ignored");
        pin_as_irq = 4'hE;
        i_eid_src_model.pulse(SRC_TIMER0, 3, 0);
        wait_flag(SRC_TIMER0);
        check(pending, 9'h000, "unconfigured timer pin ignored");
        pin_as_irq = 4'hF;
    endtask : test_refusals

    task automatic test_host_spacing();
        for (int g = 2; g <= 3; g++) begin
            fork
                i_eid_src_model.pulse(SRC_HOST, 1, g);
                begin
                    wait_flag(SRC_HOST);
                    soft_pulse();
                end
            join
            repeat (12) @(negedge clk_sys_i);
            check({8'h00, pending[SRC_HOST]}, (g == 3) ? 9'h001 : 9'h000, "second strobe");
        end
    endtask : test_host_spacing

    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        test_reset_and_writes();
        test_all_sources();
        test_ack_mask_soft();
        test_refusals();
        test_host_spacing();
        complete_run();
    end
endmodule : ext_irq_detect_ack_tb_top
`default_nettype wire
